/* ebrg_arbiter.sv */
// ebrg_arbiter: external bus request/grant arbiter with emulator pin swap and continue mode
`timescale 1ns/100ps
module ebrg_arbiter (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register port
    input wire logic [ebrg_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [ebrg_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [ebrg_pkg::DATA_W-1:0] reg_rdata,
    // normal pins, active low except bus_grant_oe
    input wire logic ext_bus_request_n,
    input wire logic sys_reset_in_n,
    output logic bus_grant_out_n,
    output logic bus_grant_oe,
    output logic grant_stalled_out_n,
    // emulator pins
    input wire logic emulator_enable,
    input wire logic emu_bus_request_n,
    input wire logic emu_reset_in_n,
    output logic emu_bus_grant_n,
    // processor core side
    input wire ebrg_pkg::ebrg_core_req_type core_req,
    output ebrg_pkg::ebrg_core_ctl_type core_ctl
);

    //==========================================================================
    // state
    typedef struct packed {
        ebrg_pkg::ebrg_state_type st;
        logic go_mode;
        logic grant;
        logic stalled;
        ebrg_pkg::ebrg_core_ctl_type ctl;
        ebrg_pkg::ebrg_pins_type pins;
        logic [ebrg_pkg::DATA_W-1:0] rdata;
    } ebrg_arb_state_type;

    ebrg_arb_state_type s_q;
    ebrg_arb_state_type s_d;

    //==========================================================================
    // pin synchronisers
    logic [2:0] sync_raw;
    logic [2:0] sync_val;
    logic ext_req_n_s;
    logic emu_req_n_s;
    logic emu_en_s;
    logic req;
    logic need;

    // request pins are asynchronous; a late edge lands one cycle later
    assign sync_raw = {emulator_enable, emu_bus_request_n, ext_bus_request_n};

    ebrg_sync #(
        .WIDTH(3),
        .RESET_VAL(3'b011)
    ) u_sync (
        .clk(clk),
        .rstn(rstn),
        .async_in(sync_raw),
        .sync_out(sync_val)
    );

    assign ext_req_n_s = sync_val[0];
    assign emu_req_n_s = sync_val[1];
    assign emu_en_s = sync_val[2];

    // emulator takes the request input in place of the normal pin
    // the core reset pin is not looked at here, so requests work in reset too
    assign req = emu_en_s ? !emu_req_n_s : !ext_req_n_s;
    assign need = core_req.cpu_ext_need || core_req.byte_mem_transfer_engine_ext_need;

    //==========================================================================
    // next state
    always_comb begin
        s_d = s_q;
        s_d.rdata = ebrg_pkg::RDATA_RESET;
        case (s_q.st)
            ebrg_pkg::ST_OWNED: begin
                // a pending request keeps the core from starting a new access
                s_d.ctl.ext_access_hold = req;
                if (req && !core_req.ext_access_busy) begin
                    s_d.st = ebrg_pkg::ST_GRANTED;
                    s_d.grant = 1'b1;
                    s_d.ctl.bus_drive_en = 1'b0;
                    s_d.ctl.cpu_halt = !s_q.go_mode || core_req.cpu_ext_need;
                    s_d.stalled = need;
                end
            end
            ebrg_pkg::ST_GRANTED: begin
                if (!req) begin
                    // bus back: drivers on, grant and stall off, pending access proceeds
                    s_d.st = ebrg_pkg::ST_OWNED;
                    s_d.grant = 1'b0;
                    s_d.stalled = 1'b0;
                    s_d.ctl.bus_drive_en = 1'b1;
                    s_d.ctl.cpu_halt = 1'b0;
                    s_d.ctl.ext_access_hold = 1'b0;
                end else begin
                    // continue mode halts only on an external access
                    s_d.ctl.cpu_halt = !s_q.go_mode || core_req.cpu_ext_need;
                    s_d.stalled = need;
                    s_d.ctl.ext_access_hold = 1'b1;
                end
            end
            default: begin
                s_d.st = ebrg_pkg::ST_OWNED;
            end
        endcase

        // the selected reset goes to the core
        s_d.ctl.core_reset_n = emu_en_s ? emu_reset_in_n : sys_reset_in_n;

        // grant routing; under the emulator the normal grant pin floats
        s_d.pins.bus_grant_oe = !emu_en_s;
        s_d.pins.bus_grant_out_n = emu_en_s ? ebrg_pkg::PIN_INACTIVE : !s_d.grant;
        s_d.pins.emu_bus_grant_n = emu_en_s ? !s_d.grant : ebrg_pkg::PIN_INACTIVE;
        s_d.pins.grant_stalled_out_n = !(s_d.stalled && s_d.grant);

        // register writes
        if (reg_wr && reg_addr == ebrg_pkg::OFS_CTRL) begin
            s_d.go_mode = reg_wdata[ebrg_pkg::CTRL_GO_BIT];
        end

        // register reads; unmapped addresses read zero
        if (reg_rd) begin
            case (reg_addr)
                ebrg_pkg::OFS_CTRL: begin
                    s_d.rdata[ebrg_pkg::CTRL_GO_BIT] = s_q.go_mode;
                end
                ebrg_pkg::OFS_STATUS: begin
                    s_d.rdata[ebrg_pkg::STAT_GRANT_BIT] = s_q.grant;
                    s_d.rdata[ebrg_pkg::STAT_STALL_BIT] = s_q.stalled;
                    s_d.rdata[ebrg_pkg::STAT_EMU_BIT] = emu_en_s;
                    s_d.rdata[ebrg_pkg::STAT_HALT_BIT] = s_q.ctl.cpu_halt;
                end
                default: begin
                    s_d.rdata = ebrg_pkg::RDATA_RESET;
                end
            endcase
        end
    end

    //==========================================================================
    // state register; pins come up inactive high
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q.st <= ebrg_pkg::ST_OWNED;
            s_q.go_mode <= ebrg_pkg::CTRL_GO_RESET;
            s_q.grant <= 1'b0;
            s_q.stalled <= 1'b0;
            s_q.ctl.cpu_halt <= 1'b0;
            s_q.ctl.bus_drive_en <= 1'b1;
            s_q.ctl.ext_access_hold <= 1'b0;
            s_q.ctl.core_reset_n <= 1'b0;
            s_q.pins.bus_grant_out_n <= ebrg_pkg::PIN_INACTIVE;
            s_q.pins.bus_grant_oe <= 1'b1;
            s_q.pins.emu_bus_grant_n <= ebrg_pkg::PIN_INACTIVE;
            s_q.pins.grant_stalled_out_n <= ebrg_pkg::PIN_INACTIVE;
            s_q.rdata <= ebrg_pkg::RDATA_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    //==========================================================================
    // outputs straight from flops
    assign reg_rdata = s_q.rdata;
    assign bus_grant_out_n = s_q.pins.bus_grant_out_n;
    assign bus_grant_oe = s_q.pins.bus_grant_oe;
    assign emu_bus_grant_n = s_q.pins.emu_bus_grant_n;
    assign grant_stalled_out_n = s_q.pins.grant_stalled_out_n;
    assign core_ctl = s_q.ctl;

    //==========================================================================
    // checks
    sequence idle_req_s;
        s_q.st == ebrg_pkg::ST_OWNED && req && !core_req.ext_access_busy;
    endsequence

    sequence granted_s;
        s_q.st == ebrg_pkg::ST_GRANTED && s_q.grant && !s_q.ctl.bus_drive_en;
    endsequence

    sequence returned_s;
        s_q.grant == 1'b0 && s_q.ctl.bus_drive_en && !s_q.ctl.cpu_halt && s_q.pins.grant_stalled_out_n;
    endsequence

    grant_next_cycle_a: assert property (@(posedge clk) disable iff (!rstn)
        idle_req_s |=> granted_s)
        else $error("grant not given one cycle after idle request");

    halt_on_grant_a: assert property (@(posedge clk) disable iff (!rstn)
        (idle_req_s and !s_q.go_mode) |=> s_q.ctl.cpu_halt)
        else $error("core not halted on grant in normal mode");

    go_mode_runs_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.st == ebrg_pkg::ST_GRANTED && req && s_q.go_mode && !core_req.cpu_ext_need) |=> !s_q.ctl.cpu_halt)
        else $error("core halted in continue mode without external access");

    busy_withhold_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.st == ebrg_pkg::ST_OWNED && core_req.ext_access_busy) |=> !s_q.grant)
        else $error("grant given during an external access");

    hold_new_access_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.st == ebrg_pkg::ST_OWNED && req) |=> s_q.ctl.ext_access_hold)
        else $error("new access not held while request pending");

    release_resume_a: assert property (@(posedge clk) disable iff (!rstn)
        (granted_s ##1 (s_q.st == ebrg_pkg::ST_GRANTED && !req)) |=> returned_s)
        else $error("bus not returned after request dropped");

    stall_when_blocked_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_q.st == ebrg_pkg::ST_GRANTED && req && need) |=> !s_q.pins.grant_stalled_out_n)
        else $error("stall output not asserted while blocked");

    stall_only_granted_a: assert property (@(posedge clk) disable iff (!rstn)
        !s_q.grant |-> s_q.pins.grant_stalled_out_n)
        else $error("stall output asserted without grant");

    stall_grant_drop_a: assert property (@(posedge clk) disable iff (!rstn)
        $fell(s_q.grant) |-> (s_q.pins.grant_stalled_out_n && !s_q.ctl.ext_access_hold))
        else $error("stall or hold left active after bus return");

    emu_grant_float_a: assert property (@(posedge clk) disable iff (!rstn)
        emu_en_s |=> (!s_q.pins.bus_grant_oe && s_q.pins.bus_grant_out_n))
        else $error("normal grant pin driven under emulator");

    emu_grant_route_a: assert property (@(posedge clk) disable iff (!rstn)
        (emu_en_s && $past(emu_en_s)) |-> (s_q.pins.emu_bus_grant_n == !s_q.grant))
        else $error("emulator grant pin does not follow grant");

    go_default_off_a: assert property (@(posedge clk)
        $rose(rstn) |-> !s_q.go_mode)
        else $error("continue mode not off after reset");

endmodule : ebrg_arbiter

/* ebrg_pkg.sv */
// ebrg_pkg: constants, register map and carrier types of the external bus request/grant arbiter
//==============================================================================
//==============================================================================
package ebrg_pkg;

    //==========================================================================
    // register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam int CTRL_GO_BIT = 0;
    localparam int STAT_GRANT_BIT = 0;
    localparam int STAT_STALL_BIT = 1;
    localparam int STAT_EMU_BIT = 2;
    localparam int STAT_HALT_BIT = 3;
    localparam logic CTRL_GO_RESET = 1'b0;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    //==========================================================================
    // synchroniser depth and pin reset levels
    localparam int SYNC_STAGES = 2;
    localparam logic PIN_INACTIVE = 1'b1;

    //==========================================================================
    // arbiter states
    typedef enum logic [0:0] {
        ST_OWNED,
        ST_GRANTED
    } ebrg_state_type;

    // what the processor core reports about its external memory traffic
    typedef struct packed {
        logic cpu_ext_need;
        logic byte_mem_transfer_engine_ext_need;
        logic ext_access_busy;
    } ebrg_core_req_type;

    // what the arbiter tells the processor core
    typedef struct packed {
        logic cpu_halt;
        logic bus_drive_en;
        logic ext_access_hold;
        logic core_reset_n;
    } ebrg_core_ctl_type;

    // pin side outputs
    typedef struct packed {
        logic bus_grant_out_n;
        logic bus_grant_oe;
        logic emu_bus_grant_n;
        logic grant_stalled_out_n;
    } ebrg_pins_type;

endpackage : ebrg_pkg

/* ebrg_sync.sv */
// ebrg_sync: multi-bit level synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module ebrg_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // asynchronous levels in, synchronous levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } ebrg_sync_state_type;

    ebrg_sync_state_type s_q;
    ebrg_sync_state_type s_d;

    // the first stage feeds only the second stage
    always_comb begin
        s_d.meta = async_in;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q.meta <= RESET_VAL;
            s_q.stable <= RESET_VAL;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.stable;

endmodule : ebrg_sync

/* ebrg_master_model.sv */
// ebrg_master_model: behavioural external bus master that requests and hands back the bus
`timescale 1ns/100ps
module ebrg_master_model (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // bench control
    input wire logic want,
    input wire logic give_back,
    // pins seen from the master side
    input wire logic grant_n,
    input wire logic stalled_n,
    output logic req_n
);
    logic back_q;
    logic back_now;

    // a return latches until want drops, so the request is not raised again at once
    assign back_now = give_back & !grant_n & !stalled_n;

    // request held low for the whole tenure, released on a stall when asked
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            req_n <= 1'b1;
            back_q <= 1'b0;
        end else begin
            back_q <= want & (back_q | back_now);
            req_n <= !(want & !back_q & !back_now);
        end
    end
endmodule : ebrg_master_model

/* ebrg_arbiter_tb.sv */
// ebrg_arbiter_tb: self-checking bench of the bus request/grant arbiter
`timescale 1ns/100ps
module ebrg_arbiter_tb;
    //==========================================================================
    // signals
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic req_n, sys_reset_in_n = 1'b1, bus_grant_out_n, bus_grant_oe, grant_stalled_out_n;
    logic emulator_enable = 1'b0, emu_bus_request_n = 1'b1, emu_reset_in_n = 1'b1, emu_bus_grant_n;
    logic want = 1'b0, give_back = 1'b0, bg_pin;
    ebrg_pkg::ebrg_core_req_type core_req = '0;
    ebrg_pkg::ebrg_core_ctl_type core_ctl;
    int err_total = 0, n_tests = 0, n;
    logic [7:0] seed = 8'h3B;
    logic [31:0] d;

    // grant pin pulled up while it floats
    assign bg_pin = bus_grant_oe ? bus_grant_out_n : 1'b1;

    ebrg_arbiter ebrg_arbiter_i (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_bus_request_n(req_n),
        .sys_reset_in_n(sys_reset_in_n), .bus_grant_out_n(bus_grant_out_n), .bus_grant_oe(bus_grant_oe),
        .grant_stalled_out_n(grant_stalled_out_n), .emulator_enable(emulator_enable),
        .emu_bus_request_n(emu_bus_request_n), .emu_reset_in_n(emu_reset_in_n),
        .emu_bus_grant_n(emu_bus_grant_n), .core_req(core_req), .core_ctl(core_ctl));
    ebrg_master_model ebrg_master_model_i (.clk(clk), .rstn(rstn), .want(want), .give_back(give_back),
        .grant_n(bg_pin), .stalled_n(grant_stalled_out_n), .req_n(req_n));

    // 50 MHz clock
    always #10 clk = ~clk;

    //==========================================================================
    // helpers
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd

    // bounded wait on one pin: 0 grant, 1 emulator grant, 2 request
    task automatic wait_pin(input int which, input logic lvl, output int cnt);
        cnt = 0;
        while (cnt < 20 && (which == 0 ? bus_grant_out_n : which == 1 ? emu_bus_grant_n : req_n) !== lvl) begin
            tick(1);
            cnt++;
        end
        // a pin that never moves counts as a mismatch even where n is not compared
        if (cnt >= 20) begin
            err_total++;
        end
    endtask : wait_pin

    //==========================================================================
    // watchdog: the whole sequence takes well under 2000 cycles
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        summarize();
    end

    // main sequence
    initial begin
        tick(1);
        chk({bus_grant_out_n, grant_stalled_out_n, bus_grant_oe, core_ctl}, 7'b111_0100);
        @(posedge clk);
        rstn <= 1'b1;
        rd(ebrg_pkg::OFS_CTRL, d);
        chk(d, 32'h0000_0000);
        // a stray write elsewhere must not reach the continue mode bit
        wr(4'h8, 32'hFFFF_FFFF);
        rd(4'hC, d);
        chk(d, 32'h0000_0000);
        rd(ebrg_pkg::OFS_CTRL, d);
        chk(d, 32'h0000_0000);
        // idle grant, counted from the request pin falling
        core_req <= 3'b100;
        want <= 1'b1;
        wait_pin(2, 1'b0, n);
        wait_pin(0, 1'b0, n);
        chk(n, 3);
        chk({core_ctl.cpu_halt, core_ctl.bus_drive_en, core_ctl.ext_access_hold}, 3'b101);
        chk(grant_stalled_out_n, 1'b0);
        rd(ebrg_pkg::OFS_STATUS, d);
        chk(d, 32'h0000_000B);
        // random core needs while granted
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            @(posedge clk);
            core_req <= {seed[0], seed[1], 1'b0};
            tick(2);
            chk(grant_stalled_out_n, !(seed[0] | seed[1]));
            chk(core_ctl.cpu_halt, 1'b1);
        end
        // master hands the bus back on a stall
        core_req <= 3'b100;
        give_back <= 1'b1;
        wait_pin(0, 1'b1, n);
        chk(n < 20, 1'b1);
        chk({core_ctl.cpu_halt, core_ctl.bus_drive_en, core_ctl.ext_access_hold, grant_stalled_out_n}, 4'b0101);
        want <= 1'b0;
        give_back <= 1'b0;
        // request during a busy external access
        tick(2);
        core_req <= 3'b101;
        want <= 1'b1;
        tick(8);
        chk({bus_grant_out_n, core_ctl.bus_drive_en, core_ctl.ext_access_hold}, 3'b111);
        core_req <= 3'b100;
        wait_pin(0, 1'b0, n);
        chk(n, 1);
        want <= 1'b0;
        wait_pin(0, 1'b1, n);
        chk(core_ctl.bus_drive_en, 1'b1);
        // continue mode
        wr(ebrg_pkg::OFS_CTRL, 32'h0000_0001);
        rd(ebrg_pkg::OFS_CTRL, d);
        chk(d, 32'h0000_0001);
        core_req <= 3'b000;
        want <= 1'b1;
        wait_pin(0, 1'b0, n);
        chk({core_ctl.cpu_halt, grant_stalled_out_n}, 2'b01);
        core_req <= 3'b100;
        tick(2);
        chk(core_ctl.cpu_halt, 1'b1);
        want <= 1'b0;
        wr(ebrg_pkg::OFS_CTRL, 32'h0000_0000);
        // grant while the core reset pin is held
        sys_reset_in_n <= 1'b0;
        tick(4);
        want <= 1'b1;
        wait_pin(0, 1'b0, n);
        chk({bus_grant_out_n, core_ctl.core_reset_n}, 2'b00);
        want <= 1'b0;
        sys_reset_in_n <= 1'b1;
        // emulator takes the pins over
        tick(4);
        emulator_enable <= 1'b1;
        emu_reset_in_n <= 1'b0;
        want <= 1'b1;
        tick(6);
        chk({bus_grant_oe, emu_bus_grant_n, core_ctl.core_reset_n}, 3'b010);
        want <= 1'b0;
        emu_bus_request_n <= 1'b0;
        wait_pin(1, 1'b0, n);
        chk({n < 20, bus_grant_oe, bus_grant_out_n}, 3'b101);
        rd(ebrg_pkg::OFS_STATUS, d);
        chk(d, 32'h0000_000F);
        emu_bus_request_n <= 1'b1;
        wait_pin(1, 1'b1, n);
        chk(n < 20, 1'b1);
        // mid-run reset with continue mode on: pins inactive again, mode back off
        wr(ebrg_pkg::OFS_CTRL, 32'h0000_0001);
        @(posedge clk);
        rstn <= 1'b0;
        tick(2);
        chk({bus_grant_out_n, grant_stalled_out_n, bus_grant_oe, core_ctl}, 7'b111_0100);
        @(posedge clk);
        rstn <= 1'b1;
        rd(ebrg_pkg::OFS_CTRL, d);
        chk(d, 32'h0000_0000);
        summarize();
    end
endmodule : ebrg_arbiter_tb
